// *** verilog/sip_core.sv ***
// SCSI interrupt merge, identity readout, FIFO threshold, transfer timing and parity
`timescale 1ns/10ps
// Overview of operation
// - DMA and SCSI interrupt sources merge onto one host interrupt output.
// - Reading DMA status clears the DMA-engine flags that were read.
// - SCSI interrupt clears only after bus status, state and int status reads.
// - Transfer done flags an interrupt only with transfer enable bit 6 set.
// - Host address error flags an interrupt, gated by the same bit 6.
// - Any DMA abort, by command or bus abort, flags an interrupt.
// - Each rising edge of the power-down input flags an interrupt.
// - In page-list mode each page completion flags, only with bit 5 set.
// - Any SCSI interrupt sets the SCSI flag, bit 4 of DMA status.
// - SCSI raises interrupt on reset, bad command, disconnect, service, done, reselect.
// - Count register top byte shows the identity code until first loaded.
// - SCSI FIFO signals DMA ready at a two-byte threshold.
// - Sync period bits 4:0 set the synchronous transfer period.
// - Offset bits 7:6 move handshake deassertion, options depend on fast clock.
// - Offset bits 5:4 delay handshake assertion by 0 to 1.5 clocks.
// - Odd parity over data plus parity; always generated on driven bytes.
// - Parity check enable resets to zero; disabled means no checking.
// - Parity error sets bus status bit 5 and asserts ATN, no interrupt.
module sip_core
  import sip_pkg::*;
#(
  parameter logic [7:0] ID_CODE = SIP_ID_CODE_DEFAULT  // Arbitrary identity value
) (
  input  wire logic        sys_clk_i,        // Core clock
  input  wire logic        rst_i,            // Async reset, active high
  input  wire logic [7:0]  s_axi_awaddr_i,   // Write address
  input  wire logic        s_axi_awvalid_i,  // Write address valid
  output logic             s_axi_awready_o,  // Write address ready
  input  wire logic [31:0] s_axi_wdata_i,    // Write data
  input  wire logic [3:0]  s_axi_wstrb_i,    // Write strobes
  input  wire logic        s_axi_wvalid_i,   // Write data valid
  output logic             s_axi_wready_o,   // Write data ready
  output logic [1:0]       s_axi_bresp_o,    // Write response
  output logic             s_axi_bvalid_o,   // Write response valid
  input  wire logic        s_axi_bready_i,   // Write response ready
  input  wire logic [7:0]  s_axi_araddr_i,   // Read address
  input  wire logic        s_axi_arvalid_i,  // Read address valid
  output logic             s_axi_arready_o,  // Read address ready
  output logic [31:0]      s_axi_rdata_o,    // Read data
  output logic [1:0]       s_axi_rresp_o,    // Read response
  output logic             s_axi_rvalid_o,   // Read data valid
  input  wire logic        s_axi_rready_i,   // Read data ready
  input  wire logic        dma_done_i,       // DMA transfer completed, pulse
  input  wire logic        dma_addr_err_i,   // Host bus address error, pulse
  input  wire logic        dma_abort_i,      // Abort by command or bus, pulse
  input  wire logic        dma_page_done_i,  // Page finished in page-list mode, pulse
  input  wire logic        power_down_input, // Power-down pin, asynchronous
  input  wire logic [SIP_SCSI_SRC_N-1:0] scsi_event_i, // SCSI interrupt causes, pulses
  input  wire logic        count_load_i,     // Transfer counter load, pulse
  input  wire logic [7:0]  count_hi_i,       // Counter top byte once loaded
  input  wire logic [7:0]  int_state_i,      // Internal state value for readback
  input  wire logic [1:0]  fifo_level_i,     // SCSI FIFO byte count, saturating
  input  wire logic [7:0]  rx_data_i,        // Byte received from SCSI bus
  input  wire logic        rx_parity_i,      // Parity bit received
  input  wire logic        rx_strobe_i,      // Received byte valid, pulse
  input  wire logic [7:0]  tx_data_i,        // Byte to drive onto SCSI bus
  output logic             tx_parity_o,      // Generated parity for tx_data_i
  output logic             atn_o,            // ATN request on parity error
  output logic             fifo_thresh_o,    // FIFO at threshold, to DMA
  output logic [4:0]       sync_period_o,    // Sync transfer period
  output logic [1:0]       req_assert_dly_o, // Handshake assertion delay, half clocks
  output logic [1:0]       req_deassert_sel_o, // Handshake deassertion selection
  output logic             fast_clock_select,  // Fast clock mode
  output logic             fast_timing_select, // Fast timing mode
  output logic             host_irq_o        // Merged host interrupt
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic        wr_err_q, rd_err_q;

  wire wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  wire rd_go = s_axi_arvalid_i && !rvalid_q;

  assign s_axi_awready_o = !aw_hold_q;
  assign s_axi_wready_o  = !w_hold_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_bresp_o   = wr_err_q ? SIP_RESP_SLVERR : SIP_RESP_OKAY;
  assign s_axi_rresp_o   = rd_err_q ? SIP_RESP_SLVERR : SIP_RESP_OKAY;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      SIP_OFS_BUS_STATUS, SIP_OFS_INT_STATE, SIP_OFS_SYNC_PER, SIP_OFS_SYNC_OFS,
      SIP_OFS_CTRL_ONE, SIP_OFS_CLK_CONV, SIP_OFS_CTRL_THREE, SIP_OFS_XFER_CNT,
      SIP_OFS_DMA_CMD, SIP_OFS_DMA_STATUS, SIP_OFS_SCSI_INT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid_i && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid_i && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      wr_err_q <= 1'b0;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      wr_err_q <= !is_mapped(awaddr_q);
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // Byte-lane 0 write strobe per register
  logic s_axi_wstrb_i_q0;
  wire wr_lane0 = wr_go && s_axi_wstrb_i_q0;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_wstrb_i_q0 <= 1'b0;
    end else if (s_axi_wvalid_i && !w_hold_q) begin
      s_axi_wstrb_i_q0 <= s_axi_wstrb_i[0];
    end
  end
  wire wr_per  = wr_lane0 && (awaddr_q == SIP_OFS_SYNC_PER);
  wire wr_ofs  = wr_lane0 && (awaddr_q == SIP_OFS_SYNC_OFS);
  wire wr_ct1  = wr_lane0 && (awaddr_q == SIP_OFS_CTRL_ONE);
  wire wr_ccf  = wr_lane0 && (awaddr_q == SIP_OFS_CLK_CONV);
  wire wr_ct3  = wr_lane0 && (awaddr_q == SIP_OFS_CTRL_THREE);
  wire wr_cmd  = wr_lane0 && (awaddr_q == SIP_OFS_DMA_CMD);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [4:0] period_q;
  logic [7:0] sofs_q, ct1_q, ct3_q, cmd_q;
  logic [2:0] ccf_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_q <= SIP_PERIOD_RST;
      sofs_q   <= 8'h00;
      ct1_q    <= 8'h00;
      ct3_q    <= 8'h00;
      cmd_q    <= 8'h00;
      ccf_q    <= 3'h0;
    end else begin
      if (wr_per) period_q <= wdata_q[4:0];
      if (wr_ofs) sofs_q <= wdata_q[7:0];
      if (wr_ct1) ct1_q <= wdata_q[7:0];
      if (wr_ct3) ct3_q <= wdata_q[7:0];
      if (wr_cmd) cmd_q <= wdata_q[7:0];
      if (wr_ccf) ccf_q <= wdata_q[2:0];
    end
  end

  assign sync_period_o      = period_q;
  assign fast_clock_select  = ct3_q[SIP_CT3_FAST_CLOCK];
  assign fast_timing_select = ct3_q[SIP_CT3_FAST_TIMING];
  assign req_assert_dly_o   = sofs_q[5:4];
  // Without fast clock the earliest (ahead half clock) option is not offered
  assign req_deassert_sel_o = (!ct3_q[SIP_CT3_FAST_CLOCK] && sofs_q[7:6] == SIP_DLY_NONE)
                              ? SIP_DLY_HALF : sofs_q[7:6];

  // ----------------------------------------------------------------
  // Power-down synchroniser and DMA interrupt flags
  // ----------------------------------------------------------------
  logic pd_m_q, pd_s_q, pd_d_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_m_q <= 1'b0;
      pd_s_q <= 1'b0;
      pd_d_q <= 1'b0;
    end else begin
      pd_m_q <= power_down_input;
      pd_s_q <= pd_m_q;
      pd_d_q <= pd_s_q;
    end
  end
  wire pd_rise = pd_s_q && !pd_d_q;

  wire xfer_en = cmd_q[SIP_CMD_TRANSFER_IRQ_EN];
  wire page_en = cmd_q[SIP_CMD_PAGE_IRQ_EN] && cmd_q[SIP_CMD_PAGE_LIST_MODE];

  logic [3:0] dma_set;
  assign dma_set[SIP_DST_POWER_DOWN_INPUT]      = pd_rise;
  assign dma_set[SIP_DST_ABORT]     = dma_abort_i;
  assign dma_set[SIP_DST_ADDR_ERR]  = dma_addr_err_i && xfer_en;
  assign dma_set[SIP_DST_PAGE_DONE] = dma_page_done_i && page_en;
  wire done_set = dma_done_i && xfer_en;

  wire rd_dst = rd_go && (s_axi_araddr_i == SIP_OFS_DMA_STATUS);
  logic [3:0] dma_flag_q;
  logic       done_q;

  // Set wins over the read clear for every flag
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_dflag
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          dma_flag_q[gi] <= 1'b0;
        end else if (dma_set[gi]) begin
          dma_flag_q[gi] <= 1'b1;
        end else if (rd_dst) begin
          dma_flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (rd_dst) begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // SCSI interrupt: cleared after all three status reads
  // ----------------------------------------------------------------
  logic [SIP_SCSI_SRC_N-1:0] scsi_cause_q;
  logic [2:0] seen_q;
  wire rd_bst = rd_go && (s_axi_araddr_i == SIP_OFS_BUS_STATUS);
  wire rd_ist = rd_go && (s_axi_araddr_i == SIP_OFS_INT_STATE);
  wire rd_sin = rd_go && (s_axi_araddr_i == SIP_OFS_SCSI_INT);
  wire [2:0] seen_d = seen_q | {rd_sin, rd_ist, rd_bst};
  wire scsi_clr = (&seen_d) && (scsi_cause_q != '0);
  wire scsi_any_set = |scsi_event_i;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scsi_cause_q <= '0;
      seen_q       <= 3'h0;
    end else if (scsi_any_set) begin
      scsi_cause_q <= scsi_cause_q | scsi_event_i;
      seen_q       <= 3'h0;
    end else if (scsi_clr) begin
      scsi_cause_q <= '0;
      seen_q       <= 3'h0;
    end else if (scsi_cause_q != '0) begin
      seen_q       <= seen_d;
    end
  end

  wire scsi_irq_flag = |scsi_cause_q;
  wire [7:0] dma_status = {2'b00, done_q, scsi_irq_flag, dma_flag_q};
  assign host_irq_o = scsi_irq_flag || done_q || (|dma_flag_q);

  // ----------------------------------------------------------------
  // Identity code, FIFO threshold, parity
  // ----------------------------------------------------------------
  logic cnt_loaded_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_loaded_q <= 1'b0;
    end else if (count_load_i) begin
      cnt_loaded_q <= 1'b1;
    end
  end
  wire [7:0] cnt_view = cnt_loaded_q ? count_hi_i : ID_CODE;

  assign fifo_thresh_o = fifo_level_i[1];
  assign tx_parity_o   = ~(^tx_data_i);

  wire par_bad = rx_strobe_i && ct1_q[SIP_CT1_PARITY_EN]
                 && !(^{rx_data_i, rx_parity_i});
  logic perr_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      perr_q <= 1'b0;
    end else if (par_bad) begin
      perr_q <= 1'b1;
    end else if (rd_bst) begin
      perr_q <= 1'b0;
    end
  end
  assign atn_o = perr_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (s_axi_araddr_i)
      SIP_OFS_BUS_STATUS: rd_mux = 8'(perr_q) << SIP_BST_PARITY_ERR;
      SIP_OFS_INT_STATE:  rd_mux = int_state_i;
      SIP_OFS_SYNC_PER:   rd_mux = {3'h0, period_q};
      SIP_OFS_SYNC_OFS:   rd_mux = sofs_q;
      SIP_OFS_CTRL_ONE:   rd_mux = ct1_q;
      SIP_OFS_CTRL_THREE: rd_mux = ct3_q;
      SIP_OFS_XFER_CNT:   rd_mux = cnt_view;
      SIP_OFS_DMA_CMD:    rd_mux = cmd_q;
      SIP_OFS_DMA_STATUS: rd_mux = dma_status;
      SIP_OFS_SCSI_INT:   rd_mux = {2'b00, scsi_cause_q};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rd_err_q <= 1'b0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_mux};
      rd_err_q <= !is_mapped(s_axi_araddr_i);
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_done_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
      (dma_done_i && !xfer_en && !done_q && !rd_dst) |=> !done_q;
  endproperty
  a_done_gate: assert property (p_done_gate) else $error("done flag set while disabled");

  property p_done_set;
    @(posedge sys_clk_i) disable iff (rst_i) done_set |=> done_q && host_irq_o;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_abort;
    @(posedge sys_clk_i) disable iff (rst_i) dma_abort_i |=> dma_flag_q[SIP_DST_ABORT];
  endproperty
  a_abort: assert property (p_abort) else $error("abort flag missing");

  property p_dst_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rd_dst && !done_set && dma_set == 4'h0) |=> (dma_flag_q == 4'h0 && !done_q);
  endproperty
  a_dst_clear: assert property (p_dst_clear) else $error("read did not clear flags");

  property p_scsi_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (scsi_irq_flag && !scsi_clr) |=> scsi_irq_flag;
  endproperty
  a_scsi_hold: assert property (p_scsi_hold) else $error("SCSI flag dropped early");

  property p_scsi_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      scsi_any_set |=> dma_status[SIP_DST_SCSI_IRQ] && host_irq_o;
  endproperty
  a_scsi_set: assert property (p_scsi_set) else $error("SCSI flag not set");

  property p_pd_edge;
    @(posedge sys_clk_i) disable iff (rst_i)
      $rose(pd_s_q) |=> dma_flag_q[SIP_DST_POWER_DOWN_INPUT];
  endproperty
  a_pd_edge: assert property (p_pd_edge) else $error("power-down flag missing");

  property p_par_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!ct1_q[SIP_CT1_PARITY_EN] && !perr_q) |=> !perr_q;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity error while disabled");

  property p_par_err;
    @(posedge sys_clk_i) disable iff (rst_i)
      (par_bad && !host_irq_o && !scsi_any_set && !done_set && dma_set == 4'h0)
        |=> atn_o && !host_irq_o;
  endproperty
  a_par_err: assert property (p_par_err) else $error("parity error not flagged");

  property p_tx_odd;
    @(posedge sys_clk_i) disable iff (rst_i) ^{tx_data_i, tx_parity_o} == 1'b1;
  endproperty
  a_tx_odd: assert property (p_tx_odd) else $error("parity not odd");

  property p_id;
    @(posedge sys_clk_i) disable iff (rst_i) !cnt_loaded_q |-> cnt_view == ID_CODE;
  endproperty
  a_id: assert property (p_id) else $error("identity code not shown");

  c_done: cover property (@(posedge sys_clk_i) disable iff (rst_i) done_set ##[1:20] rd_dst);
  c_scsi: cover property (@(posedge sys_clk_i) disable iff (rst_i) scsi_clr);
  c_perr: cover property (@(posedge sys_clk_i) disable iff (rst_i) par_bad);

endmodule : sip_core

// *** verilog/sip_pkg.sv ***
// Package: register map, field positions and encodings for the SCSI interrupt/parity/timing block
package sip_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SIP_OFS_BUS_STATUS = 8'h10;
  localparam logic [7:0] SIP_OFS_INT_STATE  = 8'h14;
  localparam logic [7:0] SIP_OFS_SYNC_PER   = 8'h18;
  localparam logic [7:0] SIP_OFS_SYNC_OFS   = 8'h1c;
  localparam logic [7:0] SIP_OFS_CTRL_ONE   = 8'h20;
  localparam logic [7:0] SIP_OFS_CLK_CONV   = 8'h24;
  localparam logic [7:0] SIP_OFS_CTRL_THREE = 8'h2c;
  localparam logic [7:0] SIP_OFS_XFER_CNT   = 8'h38;
  localparam logic [7:0] SIP_OFS_DMA_CMD    = 8'h40;
  localparam logic [7:0] SIP_OFS_DMA_STATUS = 8'h54;
  localparam logic [7:0] SIP_OFS_SCSI_INT   = 8'h60;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SIP_CMD_TRANSFER_IRQ_EN = 6;
  localparam int SIP_CMD_PAGE_IRQ_EN     = 5;
  localparam int SIP_CMD_PAGE_LIST_MODE  = 4;
  localparam int SIP_DST_POWER_DOWN_INPUT            = 0;
  localparam int SIP_DST_ABORT           = 1;
  localparam int SIP_DST_ADDR_ERR        = 2;
  localparam int SIP_DST_PAGE_DONE       = 3;
  localparam int SIP_DST_SCSI_IRQ        = 4;
  localparam int SIP_DST_DONE            = 5;
  localparam int SIP_CT1_PARITY_EN       = 4;
  localparam int SIP_CT3_FAST_CLOCK      = 3;
  localparam int SIP_CT3_FAST_TIMING     = 4;
  localparam int SIP_BST_PARITY_ERR      = 5;
  localparam int SIP_SCSI_SRC_N          = 6;

  localparam logic [4:0] SIP_PERIOD_RST = 5'h05;
  localparam logic [1:0] SIP_RESP_OKAY  = 2'b00;
  localparam logic [1:0] SIP_RESP_SLVERR = 2'b10;

  // Identity code in the top byte of the count register (value arbitrary)
  localparam logic [7:0] SIP_ID_CODE_DEFAULT = 8'h5a;

  // Handshake edge delay in half clocks, chosen by a two-bit field
  typedef enum logic [1:0] {
    SIP_DLY_NONE = 2'b00,
    SIP_DLY_HALF = 2'b01,
    SIP_DLY_ONE  = 2'b10,
    SIP_DLY_ONEH = 2'b11
  } sip_dly_t;

endpackage : sip_pkg

// *** tb/sip_scsi_peer.sv ***
// SCSI bus peer model that sends received bytes with odd or broken parity
`timescale 1ns/10ps
module sip_scsi_peer (
  input  wire logic       clk_i,    // Core clock
  input  wire logic       send_i,   // Send one byte at this edge
  input  wire logic [7:0] byte_i,   // Byte to send
  input  wire logic       bad_i,    // Break the parity of this byte
  output logic [7:0]      data_o,   // Bus data
  output logic            parity_o, // Bus parity
  output logic            strobe_o  // Byte valid
);
  initial begin
    data_o   = 8'h00;
    parity_o = 1'h0;
    strobe_o = 1'h0;
  end
  // Released lines show the inverse of the last value
  always @(posedge clk_i) begin
    strobe_o <= send_i;
    data_o   <= send_i ? byte_i : ~data_o;
    parity_o <= send_i ? (~^byte_i) ^ bad_i : ~parity_o;
  end
endmodule : sip_scsi_peer

// *** tb/sip_core_bench.sv ***
// Self-checking bench for the SCSI interrupt, parity and timing block
`timescale 1ns/10ps
module sip_core_bench;
  import sip_pkg::*;
  localparam logic [7:0] ID = 8'h3c;  // Arbitrary identity value
  logic        sys_clk_i = 1'h0, rst_i = 1'h1, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0;
  logic        rre = 1'h0, pd = 1'h0, ld = 1'h0, ps = 1'h0, pbad = 1'h0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, tx = 8'h00, chi = 8'h00, pb = 8'h00, rxd;
  logic [31:0] wd = 32'h0, rd, v, e, seed = 32'h9be89d06;
  logic [3:0]  dev = 4'h0;
  logic [5:0]  sev = 6'h00;
  logic [1:0]  fl = 2'h0, rr, rresp, adly, dsel;
  logic [4:0]  sper;
  logic [31:0] rdat;
  logic        awr, wre, bv, arr, rv, txp, atn, fth, fclk, ftim, irq, rxp, rxs;
  int          err_total = 0, n_checks = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  sip_core #(.ID_CODE(ID)) sip_core_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wre), .s_axi_bresp_o(),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .dma_done_i(dev[3]), .dma_addr_err_i(dev[2]), .dma_abort_i(dev[1]),
    .dma_page_done_i(dev[0]), .power_down_input(pd), .scsi_event_i(sev), .count_load_i(ld),
    .count_hi_i(chi), .int_state_i(8'h00), .fifo_level_i(fl), .rx_data_i(rxd),
    .rx_parity_i(rxp), .rx_strobe_i(rxs), .tx_data_i(tx), .tx_parity_o(txp), .atn_o(atn),
    .fifo_thresh_o(fth), .sync_period_o(sper), .req_assert_dly_o(adly),
    .req_deassert_sel_o(dsel), .fast_clock_select(fclk), .fast_timing_select(ftim),
    .host_irq_o(irq));
  sip_scsi_peer sip_scsi_peer_i (.clk_i(sys_clk_i), .send_i(ps), .byte_i(pb), .bad_i(pbad),
    .data_o(rxd), .parity_o(rxp), .strobe_o(rxs));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] dst_exp(input logic [31:0] c, input logic [3:0] d);
    return {26'h0, d[3] & c[6], 1'h0, d[0] & c[5] & c[4], d[2] & c[6], d[1], 1'h0};
  endfunction : dst_exp
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    awa <= a;
    wd  <= d;
    awv <= 1'h1;
    wv  <= 1'h1;
    bre <= 1'h1;
    do begin
      @(posedge sys_clk_i);
      if (awr) awv <= 1'h0;
      if (wre) wv <= 1'h0;
    end while (!bv);
    bre <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk_i);
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do begin
      @(posedge sys_clk_i);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rd = rdat;
    rr = rresp;
    rre <= 1'h0;
  endtask : rdr
  task automatic pls(input logic [3:0] d, input logic [5:0] s, input logic [7:0] b, input logic p);
    @(posedge sys_clk_i);
    dev  <= d;
    sev  <= s;
    ps   <= p;
    pb   <= b;
    pbad <= b[0];
    @(posedge sys_clk_i);
    dev <= 4'h0;
    sev <= 6'h00;
    ps  <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
  endtask : pls
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    #(50 * 20000);
    err_total++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    rdr(SIP_OFS_CTRL_ONE);
    chk(rd & 32'h10, 32'h0);
    rdr(SIP_OFS_XFER_CNT);
    chk(rd, {24'h0, ID});
    chi <= 8'ha7;
    ld  <= 1'h1;
    @(posedge sys_clk_i);
    ld <= 1'h0;
    rdr(SIP_OFS_XFER_CNT);
    chk(rd, 32'ha7);
    rdr(8'h30);
    chk({rr, rd[29:0]}, {SIP_RESP_SLVERR, 30'h0});
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      tx <= v[7:0];
      fl <= v[9:8];
      wr(SIP_OFS_SYNC_PER, v);
      chk(sper, v[4:0]);
      chk({txp, fth}, {~^v[7:0], v[9]});
      wr(SIP_OFS_SYNC_OFS, v);
      chk({dsel, adly}, {(v[7:6] == 2'h0) ? 2'h1 : v[7:6], v[5:4]});
      wr(SIP_OFS_DMA_CMD, v & 32'h70);
      pls(v[15:12], 6'h00, 8'h00, 1'h0);
      e = dst_exp(v, v[15:12]);
      chk(irq, e != 32'h0);
      rdr(SIP_OFS_DMA_STATUS);
      chk(rd & 32'h2f, e);
      chk(irq, 1'h0);
    end
    wr(SIP_OFS_CTRL_THREE, 32'h18);
    wr(SIP_OFS_CLK_CONV, 32'h0);
    wr(SIP_OFS_SYNC_PER, 32'h4);
    chk({fclk, ftim, sper}, {2'h3, 5'h04});
    pd <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
    chk(irq, 1'h1);
    rdr(SIP_OFS_DMA_STATUS);
    chk(rd & 32'h01, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    chk(irq, 1'h0);
    for (int i = 0; i < 6; i++) begin
      pls(4'h0, 6'h01 << i, 8'h00, 1'h0);
      chk(irq, 1'h1);
      rdr(SIP_OFS_DMA_STATUS);
      chk(rd & 32'h10, 32'h10);
      rdr(SIP_OFS_BUS_STATUS);
      rdr(SIP_OFS_INT_STATE);
      chk(irq, 1'h1);
      rdr(SIP_OFS_SCSI_INT);
      chk(irq, 1'h0);
    end
    pls(4'h0, 6'h00, 8'h5b, 1'h1);
    rdr(SIP_OFS_BUS_STATUS);
    chk({atn, rd[5]}, 2'h0);
    wr(SIP_OFS_CTRL_ONE, 32'h10);
    pls(4'h0, 6'h00, 8'h5a, 1'h1);
    chk(atn, 1'h0);
    pls(4'h0, 6'h00, 8'h3d, 1'h1);
    chk({atn, irq}, 2'h2);
    rdr(SIP_OFS_BUS_STATUS);
    chk(rd & 32'h20, 32'h20);
    summarize();
  end
endmodule : sip_core_bench
